// file: logic/uce_consts.svh
// offsets, field positions, reset values and masks of the error registers
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`ifndef UCE_CONSTS_SVH
`define UCE_CONSTS_SVH

`define UCE_OFS_FLAGS     12'h104
`define UCE_OFS_SUPPRESS  12'h108
`define UCE_OFS_FATALITY  12'h10c

`define UCE_BIT_UR        20
`define UCE_BIT_ECRC      19
`define UCE_BIT_MAL       18
`define UCE_BIT_OVF       17
`define UCE_BIT_UNXP      16
`define UCE_BIT_CA        15
`define UCE_BIT_CTO       14
`define UCE_BIT_FC        13
`define UCE_BIT_PSN       12
`define UCE_BIT_DLL       4

`define UCE_IMPL_MASK     32'h001ff010
`define UCE_SEV_FIXED_ONE 32'h00000001
`define UCE_FLAGS_RST     32'h00000000
`define UCE_SUPPRESS_RST  32'h00000000
`define UCE_FATALITY_RST  32'h00062011

`endif

// file: logic/uce_pkg.sv
// types shared by the error register bank
`default_nettype none
package uce_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } uce_cfg_req_t;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
    } uce_msg_t;
endpackage
`default_nettype wire

// file: logic/uce_err_route.sv
// per-error mask and severity routing of incoming error events
`timescale 1ns/10ps
`default_nettype none
`include "uce_consts.svh"
module uce_err_route (
    input  wire logic [31:0] event_i,
    input  wire logic [31:0] suppress_i,
    input  wire logic [31:0] fatality_i,
    output logic      [31:0] record_o,
    output logic             fatal_o,
    output logic             nonfatal_o
);
    always_comb begin
        record_o   = event_i & ~suppress_i & `UCE_IMPL_MASK;
        fatal_o    = |(record_o & fatality_i);
        nonfatal_o = |(record_o & ~fatality_i);
    end
endmodule
`default_nettype wire

// file: logic/uce_regs.sv
// uncorrectable error status, mask and severity registers
`timescale 1ns/10ps
`default_nettype none
`include "uce_consts.svh"
module uce_regs (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 link_rst_i,
    input  wire logic                 global_reset_input_i,
    input  wire logic                 por_i,
    input  wire uce_pkg::uce_cfg_req_t cfg_i,
    output logic      [31:0]          cfg_rdata_o,
    input  wire logic                 unsupported_request_i,
    input  wire logic                 end_to_end_crc_i,
    input  wire logic                 malformed_packet_i,
    input  wire logic                 credit_overrun_i,
    input  wire logic                 unmatched_completion_i,
    input  wire logic                 completer_abort_i,
    input  wire logic                 completion_timeout_i,
    input  wire logic                 flow_credit_protocol_i,
    input  wire logic                 poisoned_packet_i,
    input  wire logic                 link_layer_protocol_i,
    output uce_pkg::uce_msg_t         msg_o,
    output logic      [31:0]          log_enable_o
);
    // ------------------------------------------------------------------
    // reset and decode
    // ------------------------------------------------------------------
    logic        any_rst;
    logic [2:0]  pin_rst_meta_ff;
    logic [2:0]  pin_rst_sync_ff;
    logic [31:0] flags_ff;
    logic [31:0] suppress_ff;
    logic [31:0] fatality_ff;
    logic [31:0] err_vec;
    logic [31:0] record;
    logic        fatal_c;
    logic        nonfatal_c;
    logic        wr_flags;
    logic        wr_supp;
    logic        wr_fat;

    // every reset source restores the defaults
    assign any_rst = sys_rst_i | (|pin_rst_sync_ff);

    // all checks below share this clock and stand down during any reset
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (any_rst);

    // ------------------------------------------------------------------
    // pin reset synchronisers
    // ------------------------------------------------------------------
    // link, global and power-on resets come from outside this clock;
    // they take effect two edges after the pin, traded for no metastability
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_rst_meta_ff <= 3'h0;
            pin_rst_sync_ff <= 3'h0;
        end else begin
            pin_rst_meta_ff <= {por_i, global_reset_input_i, link_rst_i};
            pin_rst_sync_ff <= pin_rst_meta_ff;
        end
    end

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction

    assign wr_flags = cfg_i.wr & hit(cfg_i.addr, `UCE_OFS_FLAGS);
    assign wr_supp  = cfg_i.wr & hit(cfg_i.addr, `UCE_OFS_SUPPRESS);
    assign wr_fat   = cfg_i.wr & hit(cfg_i.addr, `UCE_OFS_FATALITY);

    // ------------------------------------------------------------------
    // error events, all from the upstream link only
    // ------------------------------------------------------------------
    always_comb begin
        err_vec                  = 32'h00000000;
        err_vec[`UCE_BIT_UR]     = unsupported_request_i;
        err_vec[`UCE_BIT_ECRC]   = end_to_end_crc_i;
        err_vec[`UCE_BIT_MAL]    = malformed_packet_i;
        err_vec[`UCE_BIT_OVF]    = credit_overrun_i;
        err_vec[`UCE_BIT_UNXP]   = unmatched_completion_i;
        err_vec[`UCE_BIT_CA]     = completer_abort_i;
        err_vec[`UCE_BIT_CTO]    = completion_timeout_i;
        err_vec[`UCE_BIT_FC]     = flow_credit_protocol_i;
        err_vec[`UCE_BIT_PSN]    = poisoned_packet_i;
        err_vec[`UCE_BIT_DLL]    = link_layer_protocol_i;
    end

    uce_err_route u_route (
        .event_i    (err_vec),
        .suppress_i (suppress_ff),
        .fatality_i (fatality_ff),
        .record_o   (record),
        .fatal_o    (fatal_c),
        .nonfatal_o (nonfatal_c)
    );

    // ------------------------------------------------------------------
    // status flags: set wins over a write-one clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            flags_ff <= `UCE_FLAGS_RST;
        end else begin
            flags_ff <= ((flags_ff & ~({32{wr_flags}} & cfg_i.wdata))
                        | record) & `UCE_IMPL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // mask and severity
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            suppress_ff <= `UCE_SUPPRESS_RST;
        end else if (wr_supp) begin
            suppress_ff <= cfg_i.wdata & `UCE_IMPL_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            fatality_ff <= `UCE_FATALITY_RST;
        end else if (wr_fat) begin
            fatality_ff <= (cfg_i.wdata & `UCE_IMPL_MASK)
                         | `UCE_SEV_FIXED_ONE;
        end
    end

    // ------------------------------------------------------------------
    // messages and read data
    // ------------------------------------------------------------------
    // messages registered so they line up with the flag update
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            msg_o <= '0;
        end else begin
            msg_o.fatal    <= fatal_c;
            msg_o.nonfatal <= nonfatal_c;
        end
    end

    // header log and first-error pointer load only for recorded errors
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            log_enable_o <= 32'h00000000;
        end else begin
            log_enable_o <= record;
        end
    end

    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            cfg_rdata_o <= 32'h00000000;
        end else if (cfg_i.rd) begin
            if (hit(cfg_i.addr, `UCE_OFS_FLAGS)) begin
                cfg_rdata_o <= flags_ff & `UCE_IMPL_MASK;
            end else if (hit(cfg_i.addr, `UCE_OFS_SUPPRESS)) begin
                cfg_rdata_o <= suppress_ff & `UCE_IMPL_MASK;
            end else if (hit(cfg_i.addr, `UCE_OFS_FATALITY)) begin
                cfg_rdata_o <= (fatality_ff & `UCE_IMPL_MASK)
                             | `UCE_SEV_FIXED_ONE;
            end else begin
                cfg_rdata_o <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // a masked event must leave its flag, message and log untouched
    a_masked_no_flag: assert property (
        (suppress_ff[`UCE_BIT_UR] && !flags_ff[`UCE_BIT_UR]
         && !$past(any_rst))
        |=> !flags_ff[`UCE_BIT_UR] || $past(!suppress_ff[`UCE_BIT_UR]))
        else $error("masked error set its flag");

    a_masked_dll: assert property (
        (link_layer_protocol_i && suppress_ff[`UCE_BIT_DLL]
         && !flags_ff[`UCE_BIT_DLL])
        |=> !flags_ff[`UCE_BIT_DLL])
        else $error("masked link layer error set its flag");

    a_masked_no_msg: assert property (
        ((err_vec & ~suppress_ff) == 32'h0)
        |=> !msg_o.fatal && !msg_o.nonfatal)
        else $error("message sent with no unmasked error");

    a_masked_no_log: assert property (
        (malformed_packet_i && suppress_ff[`UCE_BIT_MAL])
        |=> !log_enable_o[`UCE_BIT_MAL])
        else $error("masked error loaded the header log");

    a_log_unmasked: assert property (
        (completer_abort_i && !suppress_ff[`UCE_BIT_CA])
        |=> log_enable_o[`UCE_BIT_CA])
        else $error("unmasked error did not load the header log");

    // each error source raises its own flag one edge after the event
    a_set_flag_ur: assert property (
        (unsupported_request_i && !suppress_ff[`UCE_BIT_UR])
        |=> flags_ff[`UCE_BIT_UR])
        else $error("unsupported request flag not set");

    a_set_flag_ecrc: assert property (
        (end_to_end_crc_i && !suppress_ff[`UCE_BIT_ECRC])
        |=> flags_ff[`UCE_BIT_ECRC])
        else $error("end-to-end crc flag not set");

    a_set_flag_mal: assert property (
        (malformed_packet_i && !suppress_ff[`UCE_BIT_MAL])
        |=> flags_ff[`UCE_BIT_MAL])
        else $error("malformed packet flag not set");

    a_set_flag_ovf: assert property (
        (credit_overrun_i && !suppress_ff[`UCE_BIT_OVF])
        |=> flags_ff[`UCE_BIT_OVF])
        else $error("credit overrun flag not set");

    a_set_flag_unxp: assert property (
        (unmatched_completion_i && !suppress_ff[`UCE_BIT_UNXP])
        |=> flags_ff[`UCE_BIT_UNXP])
        else $error("unmatched completion flag not set");

    a_set_flag_ca: assert property (
        (completer_abort_i && !suppress_ff[`UCE_BIT_CA])
        |=> flags_ff[`UCE_BIT_CA])
        else $error("completer abort flag not set");

    a_set_flag_cto: assert property (
        (completion_timeout_i && !suppress_ff[`UCE_BIT_CTO])
        |=> flags_ff[`UCE_BIT_CTO])
        else $error("completion timeout flag not set");

    a_set_flag_fc: assert property (
        (flow_credit_protocol_i && !suppress_ff[`UCE_BIT_FC])
        |=> flags_ff[`UCE_BIT_FC])
        else $error("flow control protocol flag not set");

    a_set_flag_psn: assert property (
        (poisoned_packet_i && !suppress_ff[`UCE_BIT_PSN])
        |=> flags_ff[`UCE_BIT_PSN])
        else $error("poisoned packet flag not set");

    a_set_flag_dll: assert property (
        (link_layer_protocol_i && !suppress_ff[`UCE_BIT_DLL])
        |=> flags_ff[`UCE_BIT_DLL])
        else $error("link layer flag not set");

    // flags fall only by a written one, never by a written zero
    a_clear_one: assert property (
        (wr_flags && cfg_i.wdata[`UCE_BIT_PSN] && !poisoned_packet_i)
        |=> !flags_ff[`UCE_BIT_PSN])
        else $error("write one did not clear flag");

    a_clear_ur: assert property (
        (wr_flags && cfg_i.wdata[`UCE_BIT_UR] && !unsupported_request_i)
        |=> !flags_ff[`UCE_BIT_UR])
        else $error("write one did not clear unsupported request flag");

    a_keep_zero: assert property (
        (wr_flags && !cfg_i.wdata[`UCE_BIT_CA] && flags_ff[`UCE_BIT_CA])
        |=> flags_ff[`UCE_BIT_CA])
        else $error("write zero changed flag");

    a_no_spurious: assert property (
        (!flags_ff[`UCE_BIT_PSN] && !poisoned_packet_i)
        |=> !flags_ff[`UCE_BIT_PSN])
        else $error("flag set with no error event");

    // reserved bits are never stored, whatever is written
    a_reserved_zero: assert property (
        (flags_ff & ~`UCE_IMPL_MASK) == 32'h0
        && (suppress_ff & ~`UCE_IMPL_MASK) == 32'h0)
        else $error("reserved bits not zero");

    a_sev_fixed: assert property (
        fatality_ff[3:0] == 4'h1)
        else $error("severity fixed bits wrong");

    a_sev_reserved: assert property (
        (fatality_ff & ~(`UCE_IMPL_MASK | `UCE_SEV_FIXED_ONE))
        == 32'h0)
        else $error("severity reserved bits stored");

    a_supp_write: assert property (
        wr_supp
        |=> suppress_ff == ($past(cfg_i.wdata) & `UCE_IMPL_MASK))
        else $error("mask write not taken");

    a_sev_write: assert property (
        wr_fat |=> (fatality_ff & `UCE_IMPL_MASK)
                   == ($past(cfg_i.wdata) & `UCE_IMPL_MASK))
        else $error("severity write not taken");

    a_read_reserved: assert property (
        (cfg_i.rd && !hit(cfg_i.addr, `UCE_OFS_FATALITY))
        |=> (cfg_rdata_o & ~`UCE_IMPL_MASK) == 32'h0)
        else $error("reserved read bits not zero");

    a_read_sev_one: assert property (
        (cfg_i.rd && hit(cfg_i.addr, `UCE_OFS_FATALITY))
        |=> cfg_rdata_o[3:0] == 4'h1)
        else $error("severity low bits read wrong");

    a_read_unmapped: assert property (
        (cfg_i.rd && !hit(cfg_i.addr, `UCE_OFS_FLAGS)
         && !hit(cfg_i.addr, `UCE_OFS_SUPPRESS)
         && !hit(cfg_i.addr, `UCE_OFS_FATALITY))
        |=> cfg_rdata_o == 32'h0)
        else $error("unmapped read not zero");

    a_read_flags: assert property (
        (cfg_i.rd && hit(cfg_i.addr, `UCE_OFS_FLAGS))
        |=> cfg_rdata_o == $past(flags_ff))
        else $error("status read does not match flags");

    // severity picks the message kind
    a_fatal_msg: assert property (
        (malformed_packet_i && !suppress_ff[`UCE_BIT_MAL]
         && fatality_ff[`UCE_BIT_MAL])
        |=> msg_o.fatal)
        else $error("fatal message missing");

    a_nonfatal_msg: assert property (
        (unsupported_request_i && !suppress_ff[`UCE_BIT_UR]
         && !fatality_ff[`UCE_BIT_UR])
        |=> msg_o.nonfatal)
        else $error("nonfatal message missing");

    // every reset source restores the defaults
    a_reset_sev: assert property (
        $past(any_rst) |-> fatality_ff == `UCE_FATALITY_RST && suppress_ff == 32'h0)
        else $error("reset defaults wrong");

    a_reset_flags: assert property (
        $past(any_rst) |-> flags_ff == 32'h0 && log_enable_o == 32'h0
                           && !msg_o.fatal && !msg_o.nonfatal)
        else $error("reset left flags or outputs set");

    c_fatal:    cover property (@(posedge clk_i) msg_o.fatal);
    c_nonfatal: cover property (@(posedge clk_i) msg_o.nonfatal);
    c_clear:    cover property (@(posedge clk_i) wr_flags && |flags_ff);
    c_masked:   cover property ((err_vec & suppress_ff) != 32'h0);
    c_release:  cover property ($fell(any_rst));
endmodule
`default_nettype wire

// file: verif/uce_host_model.sv
// host-side model issuing configuration reads and writes
`timescale 1ns/10ps
`default_nettype none
module uce_host_model (
    input  wire logic             clk_i,
    input  wire logic [31:0]      rdata_i,
    output uce_pkg::uce_cfg_req_t cfg_o
);
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    initial cfg_o = '0;
    // idle address is inverted, and after a write the data too, so a stale address is never reused
    task automatic write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cfg_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        cfg_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic read(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_i);
        cfg_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h5a5a5a5a};
        @(posedge clk_i);
        cfg_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'ha5a5a5a5};
        #1 d = rdata_i;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the uncorrectable error register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                  clk_i, sys_rst_i;
    logic [2:0]            xr;
    logic [9:0]            ev;
    logic [31:0]           rdata, log_en, d, m, s, c, ex_f;
    logic [31:0]           st;
    uce_pkg::uce_cfg_req_t cfg;
    uce_pkg::uce_msg_t     msg;
    int                    n_errors, num_checks;
    // ------------------------------------------------------------
    // design, host model, clock
    // ------------------------------------------------------------
    uce_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .link_rst_i(xr[0]), .global_reset_input_i(xr[1]), .por_i(xr[2]),
        .cfg_i(cfg), .cfg_rdata_o(rdata),
        .unsupported_request_i(ev[9]), .end_to_end_crc_i(ev[8]),
        .malformed_packet_i(ev[7]), .credit_overrun_i(ev[6]),
        .unmatched_completion_i(ev[5]), .completer_abort_i(ev[4]),
        .completion_timeout_i(ev[3]), .flow_credit_protocol_i(ev[2]),
        .poisoned_packet_i(ev[1]), .link_layer_protocol_i(ev[0]),
        .msg_o(msg), .log_enable_o(log_en));
    uce_host_model host (.clk_i(clk_i), .rdata_i(rdata), .cfg_o(cfg));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    // event vector to flag positions 20..12 and 4
    function automatic logic [31:0] spread(input logic [9:0] e);
        return {11'h0, e[9:1], 7'h0, e[0], 4'h0};
    endfunction
    task automatic check(input string n, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // events are one-cycle pulses; answers land one edge later
    task automatic pulse(input logic [9:0] e, input logic [31:0] mk, sv);
        logic [31:0] u;
        u = spread(e) & ~mk;
        @(posedge clk_i) ev <= e;
        @(posedge clk_i) ev <= '0;
        #1 check("log", log_en, u);
        check("msg", {30'h0, msg}, {30'h0, |(u & sv), |(u & ~sv)});
        ex_f = ex_f | u;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        host.read(a, d);
        check("rdata", d, e);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        st = 32'hde93bd83;
        sys_rst_i = 1'b1;
        xr = '0;
        ev = '0;
        ex_f = '0;
        n_errors = 0;
        num_checks = 0;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(12'h104, 32'h0);
        rd_chk(12'h108, 32'h0);
        rd_chk(12'h10c, 32'h00062011);
        rd_chk(12'h110, 32'h0);
        host.write(12'h108, 32'hffffffff);
        rd_chk(12'h108, 32'h001ff010);
        pulse(10'h3ff, 32'hffffffff, 32'h0);
        rd_chk(12'h104, 32'h0);
        host.write(12'h10c, 32'hffffffff);
        rd_chk(12'h10c, 32'h001ff011);
        host.write(12'h10c, 32'h0);
        rd_chk(12'h10c, 32'h00000001);
        for (int i = 0; i < 40; i++) begin
            m = (i < 2) ? 32'hffe00fef : rnd();
            s = rnd();
            host.write(12'h108, m);
            host.write(12'h10c, s);
            rd_chk(12'h108, m & 32'h001ff010);
            rd_chk(12'h10c, (s & 32'h001ff010) | 32'h1);
            pulse((i < 2) ? 10'h3ff : 10'(rnd()), m & 32'h001ff010, s);
            rd_chk(12'h104, ex_f);
            c = (i == 1) ? 32'h0 : rnd();
            host.write(12'h104, c);
            ex_f = ex_f & ~c;
            rd_chk(12'h104, ex_f);
        end
        for (int r = 0; r < 3; r++) begin
            host.write(12'h108, 32'h0);
            host.write(12'h10c, 32'h0);
            pulse(10'h3ff, 32'h0, 32'h1);
            host.write(12'h108, 32'hffffffff);
            @(posedge clk_i) xr <= 3'(1 << r);
            @(posedge clk_i) xr <= '0;
            // pin resets pass a two-flop synchroniser before acting
            repeat (2) @(posedge clk_i);
            ex_f = '0;
            rd_chk(12'h104, 32'h0);
            rd_chk(12'h108, 32'h0);
            rd_chk(12'h10c, 32'h00062011);
        end
        summarize();
    end
    // whole run needs about 740 cycles
    initial begin
        repeat (10000) @(posedge clk_i);
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
